// [inc/ihb_pkg.sv]
package ihb_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int CMD8_NS = 450;
  localparam int CMD8_CYC = (CMD8_NS + CLK_NS - 1) / CLK_NS;
  localparam int CMD16_NS = 150;
  localparam int CMD16_CYC = (CMD16_NS + CLK_NS - 1) / CLK_NS;
  localparam int MASTER_MAX_US = 15;
  localparam int MASTER_MAX_CYC = (MASTER_MAX_US * 1000) / CLK_NS;
  localparam int REF_US = 15;
  localparam int REF_CYC = (REF_US * 1000) / CLK_NS;
  localparam logic [3:0] RSTDRV_HOLD = 4'hF;
  localparam logic [3:0] DMA_BLOCK_LEN = 4'h8;
  localparam logic [1:0] BUSCLK_DIV = 2'h1;
  localparam logic [3:0] CARD_WAIT = 4'h3;

  // ---------------------------------------------------------------
  // Bus layout
  // ---------------------------------------------------------------
  localparam int DMA_CASCADE_CH = 4;
  localparam int DMA_WORD_CH = 5;
  localparam int LOW_MEG_BIT = 20;
  localparam logic [9:0] CARD_IO_BASE = 10'h300;
  localparam int CARD_IRQ = 10;
  localparam int CARD_DMA_CH = 5;

  // Bus cycle states
  typedef enum logic [2:0] {
    IHB_IDLE, IHB_ADDR, IHB_CMD, IHB_END,
    IHB_DADDR, IHB_DCMD, IHB_DEND, IHB_REF
  } ihb_state_t;

endpackage : ihb_pkg

// [inc/ihb_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface ihb_if;
  logic bale;
  logic aen;
  logic [19:0] sa;
  logic [3:0] la;
  logic sbhe;
  logic addr_oe;
  logic [15:0] host_sd;
  logic host_sd_oe;
  logic [15:0] card_sd;
  logic card_sd_oe;
  logic [15:0] sd;
  logic cmd_oe;
  logic host_ior_n, host_iow_n, host_memr_n, host_memw_n;
  logic ior_n, iow_n, memr_n, memw_n;
  logic smemr_n, smemw_n;
  logic iochrdy_oe, iochrdy;
  logic iocs16_oe, iocs16_n;
  logic memcs16_oe, memcs16_n;
  logic zws_oe, zws_n;
  logic iochck_oe, iochck_n;
  logic [15:0] irq;
  logic [7:0] drq;
  logic [7:0] dack_n;
  logic tc;
  logic host_ref_oe, card_ref_oe, refresh_n;
  logic master_oe, master_n;
  logic rstdrv;
  logic busclk;
  logic osc;

  // ---------------------------------------------------------------
  // Wire levels from the enables; open-drain lines pull up
  // ---------------------------------------------------------------
  assign sd = card_sd_oe ? card_sd : (host_sd_oe ? host_sd : 16'hFFFF);
  assign ior_n = cmd_oe ? host_ior_n : 1'b1;
  assign iow_n = cmd_oe ? host_iow_n : 1'b1;
  assign memr_n = cmd_oe ? host_memr_n : 1'b1;
  assign memw_n = cmd_oe ? host_memw_n : 1'b1;
  assign iochrdy = ~iochrdy_oe;
  assign iocs16_n = ~iocs16_oe;
  assign memcs16_n = ~memcs16_oe;
  assign zws_n = ~zws_oe;
  assign iochck_n = ~iochck_oe;
  assign refresh_n = ~(host_ref_oe | card_ref_oe);
  assign master_n = ~master_oe;

  modport host (
    output bale, aen, sa, la, sbhe, addr_oe, host_sd, host_sd_oe, cmd_oe,
    output host_ior_n, host_iow_n, host_memr_n, host_memw_n,
    output smemr_n, smemw_n, dack_n, tc, host_ref_oe, rstdrv, busclk, osc,
    input sd, iochrdy, iocs16_n, memcs16_n, zws_n, iochck_n, irq, drq,
    input refresh_n, master_n
  );
  modport card (
    output card_sd, card_sd_oe, iochrdy_oe, iocs16_oe, memcs16_oe, zws_oe,
    output iochck_oe, irq, drq, card_ref_oe, master_oe,
    input bale, aen, sa, la, sbhe, sd, ior_n, iow_n, memr_n, memw_n,
    input smemr_n, smemw_n, dack_n, tc, refresh_n, rstdrv, busclk, osc
  );
endinterface : ihb_if
`default_nettype wire

// [verilog/ihb_buf2.sv]
`timescale 1ns/10ps
`default_nettype none
module ihb_buf2
  import ihb_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  // ---------------------------------------------------------------
  // Two entries so a stalled reader loses no word
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } ihb_buf_t;

  ihb_buf_t s, next_s;
  logic push, pop;

  assign in_ready = (s.cnt != 2'h2);
  assign out_valid = (s.cnt != 2'h0);
  assign out_data = s.mem[s.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = ~s.wp;
    end
    if (pop) begin
      next_s.rp = ~s.rp;
    end
    next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : ihb_buf2
`default_nettype wire

// [verilog/ihb_host.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Address held stable across latch enable fall
// - Latch enable stays high in DMA cycles
// - AEN high for DMA, low for CPU
// - Slave holds ready low; host stretches cycle
// - Interrupts fixed priority 9..13, 15 then 3..7
// - DMA 0-3 byte wide, 5-7 word wide
// - Card holds DMA request until done
// - DMA grant priority 0,1,2,3,5,6,7
// - Active-low acknowledge per granted channel
// - Pulse TC at terminal count
// - Channel 4 cascades byte unit, seven channels
// - Master holds bus at most 15 us
// - Memory 16-bit select: word, one wait
// - I/O 16-bit select: word, one wait
// - Zero-wait line ends cycle at once
// - SBHE marks valid high data byte
// - Reset drive high on power, low line, reset
// - Read strobe: slave drives; write: slave captures
// - Low-meg strobes only below 1 MB
// - Either side drives refresh low; the card here ties its refresh enable off, so only the host drives it
// - Channel check line flags parity error
// - Free-running oscillator and bus clock out
module ihb_host
  import ihb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  ihb_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_io,
  input wire logic cmd_wr,
  input wire logic cmd_word,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [15:0] rsp_data,
  output logic irq_valid,
  output logic [3:0] irq_id,
  output logic chan_check,
  output logic master_overrun,
  input wire logic power_fail,
  input wire logic hw_reset
);

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    ihb_state_t st;
    logic [3:0] wcnt;
    logic bale;
    logic aen;
    logic [23:0] addr;
    logic [15:0] sd;
    logic sd_oe;
    logic io;
    logic wr;
    logic word;
    logic ior, iow, memr, memw;
    logic [7:0] dack;
    logic [2:0] dch;
    logic [3:0] dcnt;
    logic [15:0] daddr;
    logic tc;
    logic [15:0] rd;
    logic push;
    logic [8:0] refcnt;
    logic ref_oe;
    logic [8:0] mcnt;
    logic m_over;
    logic chk;
    logic [3:0] rcnt;
    logic rstdrv;
    logic [1:0] bdiv;
    logic busclk;
    logic osc;
    logic irq_v;
    logic [3:0] irq_id;
  } ihb_host_t;

  ihb_host_t s, next_s;
  logic buf_ready;
  logic master;
  logic [7:0] dreq;
  logic dgo;
  logic [2:0] dsel;
  logic ivalid;
  logic [3:0] isel;

  localparam logic [8:0] REF_LAST = 9'(REF_CYC - 1);
  localparam logic [8:0] MASTER_LAST = 9'(MASTER_MAX_CYC);
  // Countdown ends on zero, so one less than the strobe width
  localparam logic [3:0] CMD8_W = 4'(CMD8_CYC - 1);
  localparam logic [3:0] CMD16_W = 4'(CMD16_CYC - 1);
  localparam logic [3:0] IRQ_ORDER [11] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
    4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};

  assign master = ~bus.master_n;

  // ---------------------------------------------------------------
  // Priority encoders
  // ---------------------------------------------------------------
  // Channel 4 is the cascade link, never a requester
  always_comb begin
    dreq = bus.drq;
    dreq[DMA_CASCADE_CH] = 1'b0;
    dgo = 1'b0;
    dsel = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (dreq[i]) begin
        dgo = 1'b1;
        dsel = 3'(i);
      end
    end
  end

  // Walk lowest priority first so the highest wins
  always_comb begin
    ivalid = 1'b0;
    isel = 4'h0;
    for (int i = 10; i >= 0; i--) begin
      if (bus.irq[IRQ_ORDER[i]]) begin
        ivalid = 1'b1;
        isel = IRQ_ORDER[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.tc = 1'b0;
    next_s.push = 1'b0;
    next_s.irq_v = ivalid;
    next_s.irq_id = isel;
    next_s.chk = ~bus.iochck_n;
    // Reset drive stretched past any reset source
    if (power_fail || hw_reset) begin
      next_s.rcnt = RSTDRV_HOLD;
      next_s.rstdrv = 1'b1;
    end else if (s.rcnt != 4'h0) begin
      next_s.rcnt = s.rcnt - 4'h1;
    end else begin
      next_s.rstdrv = 1'b0;
    end
    // Clocks cannot reach 14.31818 MHz from 20 MHz; nearest is a toggle
    next_s.osc = ~s.osc;
    if (s.bdiv == BUSCLK_DIV) begin
      next_s.bdiv = 2'h0;
      next_s.busclk = ~s.busclk;
    end else begin
      next_s.bdiv = s.bdiv + 2'h1;
    end
    // Refresh due counter keeps running under a master
    if (s.refcnt != REF_LAST) begin
      next_s.refcnt = s.refcnt + 9'h1;
    end
    // Master hold watchdog
    if (master) begin
      if (s.mcnt != MASTER_LAST) begin
        next_s.mcnt = s.mcnt + 9'h1;
      end else begin
        next_s.m_over = 1'b1;
      end
    end else begin
      next_s.mcnt = 9'h0;
    end
    case (s.st)
      IHB_IDLE: begin
        next_s.bale = 1'b0;
        next_s.aen = 1'b0;
        next_s.sd_oe = 1'b0;
        if (master || s.rstdrv) begin
          next_s.st = IHB_IDLE;
        end else if (s.refcnt == REF_LAST) begin
          next_s.st = IHB_REF;
          next_s.refcnt = 9'h0;
          next_s.ref_oe = 1'b1;
          next_s.memr = 1'b1;
          next_s.wcnt = CMD8_W;
          next_s.addr = {16'h0, s.daddr[7:0]};
        end else if (dgo) begin
          next_s.st = IHB_DADDR;
          next_s.dch = dsel;
          next_s.dcnt = DMA_BLOCK_LEN;
          next_s.aen = 1'b1;
          next_s.bale = 1'b1;
          next_s.word = (dsel >= 3'(DMA_WORD_CH));
          next_s.addr = {8'h0, s.daddr};
        end else if (cmd_valid) begin
          next_s.st = IHB_ADDR;
          next_s.bale = 1'b1;
          next_s.addr = cmd_addr;
          next_s.io = cmd_io;
          next_s.wr = cmd_wr;
          next_s.word = cmd_word;
          next_s.sd = cmd_wdata;
        end
      end
      IHB_ADDR: begin
        // Address held through the falling edge of latch enable
        next_s.bale = 1'b0;
        next_s.st = IHB_CMD;
        next_s.sd_oe = s.wr;
        next_s.ior = s.io & ~s.wr;
        next_s.iow = s.io & s.wr;
        next_s.memr = ~s.io & ~s.wr;
        next_s.memw = ~s.io & s.wr;
        // Size decided from the select sampled on the valid address
        if ((s.io && !bus.iocs16_n) || (!s.io && !bus.memcs16_n)) begin
          next_s.wcnt = CMD16_W;
        end else begin
          next_s.wcnt = CMD8_W;
        end
      end
      IHB_CMD, IHB_DCMD, IHB_REF: begin
        if (s.wcnt != 4'h0) begin
          next_s.wcnt = s.wcnt - 4'h1;
        end
        // Zero-wait ends at once; ready low stretches
        if ((!bus.zws_n && s.st == IHB_CMD) ||
            (s.wcnt == 4'h0 && bus.iochrdy)) begin
          next_s.ior = 1'b0;
          next_s.iow = 1'b0;
          next_s.memr = 1'b0;
          next_s.memw = 1'b0;
          next_s.ref_oe = 1'b0;
          next_s.rd = bus.sd;
          next_s.st = (s.st == IHB_CMD) ? IHB_END :
                      (s.st == IHB_DCMD) ? IHB_DEND : IHB_IDLE;
          if (s.st == IHB_REF) begin
            next_s.daddr = s.daddr + 16'h1;
          end
        end
      end
      IHB_END: begin
        next_s.sd_oe = 1'b0;
        // Held here while the answer buffer is full
        if (buf_ready) begin
          next_s.push = 1'b1;
          next_s.st = IHB_IDLE;
        end
      end
      IHB_DADDR: begin
        // Peripheral to memory: read strobe and memory write together
        next_s.dack[s.dch] = 1'b1;
        next_s.ior = 1'b1;
        next_s.memw = 1'b1;
        next_s.wcnt = s.word ? CMD16_W : CMD8_W;
        next_s.st = IHB_DCMD;
        // Count pulse rides the last beat while acknowledge is low
        next_s.tc = (s.dcnt == 4'h1);
      end
      IHB_DEND: begin
        next_s.dcnt = s.dcnt - 4'h1;
        next_s.daddr = s.daddr + (s.word ? 16'h2 : 16'h1);
        if (s.dcnt == 4'h1) begin
          next_s.dack = 8'h0;
          next_s.bale = 1'b0;
          next_s.aen = 1'b0;
          next_s.st = IHB_IDLE;
        end else if (bus.drq[s.dch]) begin
          next_s.addr = {8'h0, next_s.daddr};
          next_s.st = IHB_DADDR;
        end else begin
          next_s.dack = 8'h0;
          next_s.bale = 1'b0;
          next_s.aen = 1'b0;
          next_s.st = IHB_IDLE;
        end
      end
      default: begin
        next_s.st = IHB_IDLE;
      end
    endcase
  end

  // Reset drive comes up asserted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.rstdrv <= 1'b1;
      s.rcnt <= RSTDRV_HOLD;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Answer buffer
  // ---------------------------------------------------------------
  ihb_buf2 #(.W(16)) u_rsp (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(s.push),
    .in_ready(buf_ready),
    .in_data(s.rd),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  assign cmd_ready = (s.st == IHB_IDLE) & ~master & ~s.rstdrv & ~dgo &
                     (s.refcnt != REF_LAST);
  assign bus.addr_oe = ~master;
  assign bus.cmd_oe = ~master;
  assign bus.bale = s.bale;
  assign bus.aen = s.aen;
  assign bus.sa = s.addr[19:0];
  assign bus.la = s.addr[23:20];
  assign bus.sbhe = s.word;
  assign bus.host_sd = s.sd;
  assign bus.host_sd_oe = s.sd_oe & ~master;
  assign bus.host_ior_n = ~s.ior;
  assign bus.host_iow_n = ~s.iow;
  assign bus.host_memr_n = ~s.memr;
  assign bus.host_memw_n = ~s.memw;
  assign bus.smemr_n = ~(s.memr & ~s.addr[LOW_MEG_BIT] &
                         (s.addr[23:21] == 3'h0));
  assign bus.smemw_n = ~(s.memw & ~s.addr[LOW_MEG_BIT] &
                         (s.addr[23:21] == 3'h0));
  assign bus.dack_n = ~s.dack;
  assign bus.tc = s.tc;
  assign bus.host_ref_oe = s.ref_oe;
  assign bus.rstdrv = s.rstdrv;
  assign bus.busclk = s.busclk;
  assign bus.osc = s.osc;
  assign irq_valid = s.irq_v;
  assign irq_id = s.irq_id;
  assign chan_check = s.chk;
  assign master_overrun = s.m_over;

endmodule : ihb_host
`default_nettype wire

// [verilog/ihb_card.sv]
`timescale 1ns/10ps
`default_nettype none
module ihb_card
  import ihb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  ihb_if.card bus,
  input wire logic irq_req,
  input wire logic dma_req,
  input wire logic parity_err,
  input wire logic slow,
  input wire logic take_bus,
  output logic wr_seen,
  output logic [15:0] wr_data,
  output logic dma_done
);

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0][15:0] mem;
    logic [15:0] wbuf;
    logic [1:0] widx;
    logic iow_q;
    logic [3:0] rcnt;
    logic drq;
    logic done;
    logic seen;
    logic [8:0] mcnt;
    logic mst;
  } ihb_card_t;

  ihb_card_t s, next_s;
  logic sel;
  logic [7:0] drq_v;
  logic [15:0] irq_v;

  localparam logic [8:0] MASTER_LAST = 9'(MASTER_MAX_CYC - 1);

  // Decode on latched address, CPU cycles only
  assign sel = ~bus.aen & (bus.sa[9:3] == CARD_IO_BASE[9:3]);

  always_comb begin
    next_s = s;
    next_s.seen = 1'b0;
    next_s.done = 1'b0;
    next_s.iow_q = bus.iow_n;
    // Write data captured while strobe is low, stored at its release
    if (sel && !bus.iow_n) begin
      next_s.wbuf = bus.sd;
      next_s.widx = bus.sa[2:1];
    end
    if (!s.iow_q && bus.iow_n) begin
      next_s.mem[s.widx] = s.wbuf;
      next_s.seen = 1'b1;
    end
    // Ready held low a few cycles from the address phase
    if (sel && slow && bus.bale) begin
      next_s.rcnt = CARD_WAIT;
    end else if (s.rcnt != 4'h0 && (!bus.ior_n || !bus.iow_n)) begin
      next_s.rcnt = s.rcnt - 4'h1;
    end
    // Request held until the block ends on terminal count
    if (dma_req) begin
      next_s.drq = 1'b1;
    end else if (!bus.dack_n[CARD_DMA_CH] && bus.tc) begin
      next_s.drq = 1'b0;
      next_s.done = 1'b1;
    end
    // Bus hold cut off before refresh starves
    if (take_bus && s.mcnt != MASTER_LAST) begin
      next_s.mst = 1'b1;
      next_s.mcnt = s.mcnt + 9'h1;
    end else begin
      next_s.mst = 1'b0;
      if (!take_bus) begin
        next_s.mcnt = 9'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.iow_q <= 1'b1;
    end else if (bus.rstdrv) begin
      s <= '0;
      s.iow_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  always_comb begin
    drq_v = 8'h0;
    drq_v[CARD_DMA_CH] = s.drq;
    irq_v = 16'h0;
    irq_v[CARD_IRQ] = irq_req;
  end

  assign bus.card_sd = s.mem[bus.sa[2:1]];
  assign bus.card_sd_oe = sel & ~bus.ior_n;
  assign bus.iochrdy_oe = s.rcnt != 4'h0;
  assign bus.iocs16_oe = sel;
  assign bus.memcs16_oe = (bus.la == 4'hF);
  assign bus.zws_oe = (bus.la == 4'hE);
  assign bus.iochck_oe = parity_err;
  assign bus.irq = irq_v;
  assign bus.drq = drq_v;
  assign bus.card_ref_oe = 1'b0;
  assign bus.master_oe = s.mst;
  assign wr_seen = s.seen;
  assign wr_data = s.mem[s.widx];
  assign dma_done = s.done;

endmodule : ihb_card
`default_nettype wire

// [test/ihb_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module ihb_chk import ihb_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic bale,
  input wire logic aen,
  input wire logic [19:0] sa,
  input wire logic [3:0] la,
  input wire logic cmd_oe,
  input wire logic addr_oe,
  input wire logic host_sd_oe,
  input wire logic ior_n,
  input wire logic memr_n,
  input wire logic smemr_n,
  input wire logic iochrdy,
  input wire logic iocs16_n,
  input wire logic [7:0] dack_n,
  input wire logic tc,
  input wire logic master_n
);
  // ------------------------------------------------------------
  // Read strobe width
  // ------------------------------------------------------------
  logic [4:0] low_cnt;
  logic was16;
  logic waited;
  // Wait history kept so a stretched cycle is not judged by width
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 5'h00;
      was16 <= 1'b0;
      waited <= 1'b0;
    end else if (ior_n) begin
      low_cnt <= 5'h00;
      was16 <= ~iocs16_n;
      waited <= ~iochrdy;
    end else begin
      low_cnt <= low_cnt + 5'h01;
      waited <= waited | ~iochrdy;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_addr_hold: assert property ($fell(bale) |-> $stable(sa))
    else $error("address moved at latch fall");
  a_dma_bale: assert property (aen |-> bale)
    else $error("latch enable low in dma cycle");
  a_ack_owner: assert property (dack_n != 8'hFF |-> aen)
    else $error("acknowledge without dma address");
  a_ack_single: assert property ($onehot0(~dack_n) && dack_n[4])
    else $error("bad acknowledge pattern");
  a_ready_stretch: assert property (!ior_n && !iochrdy |=> !ior_n)
    else $error("strobe ended while not ready");
  a_io_width: assert property ($rose(ior_n) && !aen && !waited
    |-> low_cnt == (was16 ? CMD16_CYC : CMD8_CYC))
    else $error("io read strobe width wrong");
  a_dma_width: assert property ($rose(ior_n) && aen && !waited
    |-> low_cnt == CMD16_CYC)
    else $error("word dma strobe width wrong");
  a_low_meg: assert property (!smemr_n |-> !memr_n && la == 4'h0)
    else $error("low meg strobe out of range");
  a_master_off: assert property (!master_n |-> !cmd_oe && !addr_oe)
    else $error("host drives during master");
  a_tc_pulse: assert property (tc |=> !tc)
    else $error("terminal count not a pulse");
endmodule : ihb_chk
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench import ihb_pkg::*; ;
  logic core_clk, resetn, cmd_valid, cmd_ready, cmd_io, cmd_wr, cmd_word;
  logic rsp_valid, rsp_ready, irq_valid, chan_check, master_overrun;
  logic power_fail, hw_reset, irq_req, dma_req, parity_err, slow, take_bus;
  logic wr_seen, dma_done, sbhe_l, aen_l, smem_f, mem_f, pior;
  logic [23:0] cmd_addr;
  logic [19:0] sa_l;
  logic [15:0] cmd_wdata, rsp_data, wr_data;
  logic [3:0] irq_id;
  int num_errors = 0, samples_checked = 0, cyc = 0, cur = 0, last = 0;
  int tcs = 0, nxf = 0, dones = 0, seens = 0;

  ihb_if bus_if();
  ihb_host ihb_host_i (.core_clk(core_clk), .resetn(resetn), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_io(cmd_io),
    .cmd_wr(cmd_wr), .cmd_word(cmd_word), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .irq_valid(irq_valid), .irq_id(irq_id),
    .chan_check(chan_check), .master_overrun(master_overrun),
    .power_fail(power_fail), .hw_reset(hw_reset));
  ihb_card ihb_card_i (.core_clk(core_clk), .resetn(resetn), .bus(bus_if),
    .irq_req(irq_req), .dma_req(dma_req), .parity_err(parity_err),
    .slow(slow), .take_bus(take_bus), .wr_seen(wr_seen),
    .wr_data(wr_data), .dma_done(dma_done));
  ihb_chk ihb_chk_i (.core_clk(core_clk), .resetn(resetn),
    .bale(bus_if.bale), .aen(bus_if.aen), .sa(bus_if.sa), .la(bus_if.la),
    .cmd_oe(bus_if.cmd_oe), .addr_oe(bus_if.addr_oe),
    .host_sd_oe(bus_if.host_sd_oe), .ior_n(bus_if.ior_n),
    .memr_n(bus_if.memr_n), .smemr_n(bus_if.smemr_n),
    .iochrdy(bus_if.iochrdy), .iocs16_n(bus_if.iocs16_n),
    .dack_n(bus_if.dack_n), .tc(bus_if.tc), .master_n(bus_if.master_n));

  // ------------------------------------------------------------
  // Clock, bus watchers, common tasks
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Strobe widths outside refresh, dma beats, flags, hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      num_errors++;
      finish_test();
    end
    if (bus_if.refresh_n) begin
      if (!(bus_if.ior_n & bus_if.iow_n & bus_if.memr_n & bus_if.memw_n))
        cur++;
      else if (cur > 0) begin
        last = cur;
        cur = 0;
      end
      smem_f |= !bus_if.smemr_n;
      mem_f |= !bus_if.memr_n;
    end
    tcs += bus_if.tc;
    if (bus_if.aen && pior && !bus_if.ior_n) nxf++;
    pior = bus_if.ior_n;
    dones += dma_done;
    seens += wr_seen;
  end
  // Capture what a card latches at the latch enable fall
  always @(negedge bus_if.bale) begin
    sa_l = bus_if.sa;
    sbhe_l = bus_if.sbhe;
    aen_l = bus_if.aen;
  end
  task automatic check(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle
  // Request held from a falling edge until the edge that takes it
  task automatic op(input logic io, wr, wd, input logic [23:0] a,
      input logic [15:0] d);
    int n;
    n = 0;
    smem_f = 1'b0;
    mem_f = 1'b0;
    {cmd_io, cmd_wr, cmd_word, cmd_addr, cmd_wdata} = {io, wr, wd, a, d};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 900) begin
      idle(1);
      n++;
    end
    check("cmd_ready", cmd_ready, 1);
    idle(1);
    cmd_valid = 1'b0;
    idle(1);
  endtask : op
  task automatic pop(input logic [15:0] e);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      idle(1);
      n++;
    end
    check("rsp_valid", rsp_valid, 1);
    check("rsp_data", rsp_data, e);
    rsp_ready = 1'b1;
    idle(1);
    rsp_ready = 1'b0;
    idle(1);
  endtask : pop

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    idle(5);
    check("rstdrv", bus_if.rstdrv, 1);
    while (cmd_ready !== 1'b1 && n < 40) begin
      idle(1);
      n++;
    end
    check("rstdrv", bus_if.rstdrv, 0);
  endtask : t_reset
  task automatic t_io();
    op(1'b1, 1'b1, 1'b1, 24'h000300, 16'hA55A);
    pop(16'hA55A);
    check("wr_data", wr_data, 16'hA55A);
    check("sa", sa_l, 20'h00300);
    check("aen", aen_l, 0);
    check("sbhe", sbhe_l, 1);
    check("width16", last, CMD16_CYC);
    slow = 1'b1;
    op(1'b1, 1'b0, 1'b1, 24'h000300, 16'h0000);
    pop(16'hA55A);
    check("stretch", last > CMD16_CYC, 1);
    slow = 1'b0;
  endtask : t_io
  task automatic t_mem();
    op(1'b0, 1'b0, 1'b0, 24'h0F0000, 16'h0000);
    pop(16'hFFFF);
    check("smem_low", smem_f, 1);
    check("sbhe", sbhe_l, 0);
    check("width8", last, CMD8_CYC);
    op(1'b0, 1'b0, 1'b0, 24'h100000, 16'h0000);
    pop(16'hFFFF);
    check("smem_high", smem_f, 0);
    check("mem_high", mem_f, 1);
    op(1'b0, 1'b0, 1'b0, 24'hF00000, 16'h0000);
    pop(16'hFFFF);
    check("width16m", last, CMD16_CYC);
    op(1'b0, 1'b0, 1'b0, 24'hE00000, 16'h0000);
    pop(16'hFFFF);
    check("width0ws", last, 1);
  endtask : t_mem
  // Answer buffer filled until the host stalls, then drained
  task automatic t_full();
    for (int i = 0; i < 3; i++) begin
      op(1'b1, 1'b1, 1'b1, {21'h60, 3'(2 * i)}, 16'(16'h1111 * (i + 1)));
    end
    idle(30);
    check("stall", cmd_ready, 0);
    for (int i = 0; i < 3; i++) begin
      pop(16'(16'h1111 * (i + 1)));
    end
    check("wr_seen", seens, 4);
  endtask : t_full
  task automatic t_dma();
    int n;
    n = 0;
    {tcs, nxf, dones} = '0;
    dma_req = 1'b1;
    idle(1);
    dma_req = 1'b0;
    while (dones == 0 && n < 600) begin
      idle(1);
      n++;
    end
    check("tc_count", tcs, 1);
    check("beats", nxf, DMA_BLOCK_LEN);
    check("dma_width", last, CMD16_CYC);
  endtask : t_dma
  task automatic t_side();
    irq_req = 1'b1;
    parity_err = 1'b1;
    idle(3);
    check("irq_valid", irq_valid, 1);
    check("irq_id", irq_id, CARD_IRQ);
    check("chan_check", chan_check, 1);
    irq_req = 1'b0;
    parity_err = 1'b0;
    idle(3);
    check("irq_valid", irq_valid, 0);
    check("chan_check", chan_check, 0);
  endtask : t_side
  task automatic t_master();
    int osc_n, clk_n;
    logic po, pb;
    {osc_n, clk_n} = '0;
    take_bus = 1'b1;
    idle(5);
    check("master", bus_if.master_n, 0);
    check("ready", cmd_ready, 0);
    idle(310);
    check("master", bus_if.master_n, 1);
    check("overrun", master_overrun, 0);
    take_bus = 1'b0;
    {po, pb} = {bus_if.osc, bus_if.busclk};
    for (int i = 0; i < 40; i++) begin
      idle(1);
      osc_n += (bus_if.osc !== po);
      clk_n += (bus_if.busclk !== pb);
      {po, pb} = {bus_if.osc, bus_if.busclk};
    end
    check("osc", osc_n, 40);
    check("busclk", clk_n, 20);
  endtask : t_master

  initial begin
    {cmd_valid, cmd_io, cmd_wr, cmd_word, rsp_ready} = '0;
    {power_fail, hw_reset, irq_req, dma_req, parity_err} = '0;
    {slow, take_bus, resetn, cmd_addr, cmd_wdata} = '0;
    idle(10);
    resetn = 1'b1;
    t_reset();
    t_io();
    t_mem();
    t_full();
    t_dma();
    t_side();
    t_master();
    hw_reset = 1'b1;
    idle(2);
    hw_reset = 1'b0;
    t_reset();
    power_fail = 1'b1;
    idle(2);
    power_fail = 1'b0;
    t_reset();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
